// [rtl/metering_irq_status_and_config.sv]
// register block: zero-cross routing, channel test, metering irq status
//
// Register access over AXI4-Lite was decided locally.
`include "metering_irq_params.svh"
`timescale 1ns/10ps
`default_nettype none

module metering_irq_status_and_config (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output metering_irq_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output metering_irq_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic voltageCrossing,
  input wire logic softResetDone,
  input wire logic tamperFaultMode,
  input wire logic reactiveNegative,
  input wire logic activeNegative,
  input wire logic apparentNoloadEvt,
  input wire logic rmsNoloadEvt,
  input wire logic reactiveNoloadEvt,
  input wire logic activeNoloadEvt,
  input wire logic [1:0] freqOutPulse,
  input wire logic [2:0] energyOverflowEvt,
  input wire logic [2:0] energyHalfEvt,
  input wire logic waveformSampleEvt,
  input wire logic currentPeakEvt,
  input wire logic voltagePeakEvt,
  input wire logic lineCycleDoneEvt,
  input wire logic crossingTimeoutEvt,
  input wire logic tamperUsesInputB,
  output logic zeroCrossPinAOut,
  output logic zeroCrossPinAOe,
  output logic zeroCrossPinBOut,
  output logic zeroCrossPinBOe,
  output logic currentInputSelB,
  output logic voltageInputGround,
  output logic currentInputGround,
  output logic combinedIrq
);
  import metering_irq_pkg::*;

  // ***********************************************************
  // bus slave
  // ***********************************************************
  byte_t zeroCrossCfg_q, calCfg_q, accCfg_q;
  byte_t enLow_q, enMid_q, enHigh_q;
  byte_t stLow_q, stMid_q, stHigh_q;
  logic [7:0] awIdx_q;
  logic awHeld_q, wHeld_q;
  logic [7:0] wByte_q;
  logic wLane_q;
  logic doWrite;
  logic [7:0] evtLevels;

  function automatic logic idxMapped(input logic [7:0] idx);
    case (idx)
      `IDX_ZERO_CROSS_OUTPUT_CONFIG, `IDX_CHANNEL_CALIBRATION_CONFIG,
      `IDX_IRQ_ENABLE_LOW, `IDX_IRQ_ENABLE_MID, `IDX_IRQ_ENABLE_HIGH,
      `IDX_IRQ_STATUS_LOW, `IDX_IRQ_STATUS_MID, `IDX_IRQ_STATUS_HIGH,
      `IDX_ACCUMULATION_CONFIG, `IDX_EVENT_LEVELS: idxMapped = 1'b1;
      default: idxMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] addrIdx(input logic [31:0] a);
    addrIdx = (a[31:10] == 22'h0) ? a[9:2] : 8'hFF;
  endfunction

  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      awIdx_q <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awIdx_q <= addrIdx(s_axi_awaddr);
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wHeld_q <= 1'b0;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= idxMapped(awIdx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wrEn;
  assign wrEn = doWrite && wLane_q;

  function automatic logic wrHit(input logic en, input logic [7:0] a,
                                 input logic [7:0] idx);
    wrHit = en && (a == idx);
  endfunction

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      zeroCrossCfg_q <= `ZX_CFG_RESET;
      calCfg_q <= `CAL_CFG_RESET;
      accCfg_q <= `ACC_CFG_RESET;
      enLow_q <= `ENABLE_RESET;
      enMid_q <= `ENABLE_RESET;
      enHigh_q <= `ENABLE_RESET;
    end else begin
      if (wrHit(wrEn, awIdx_q, `IDX_ZERO_CROSS_OUTPUT_CONFIG))
        zeroCrossCfg_q <= wByte_q & 8'h03;
      // reserved fields stored as written; software keeps them zero
      if (wrHit(wrEn, awIdx_q, `IDX_CHANNEL_CALIBRATION_CONFIG))
        calCfg_q <= wByte_q;
      if (wrHit(wrEn, awIdx_q, `IDX_ACCUMULATION_CONFIG))
        accCfg_q <= wByte_q;
      if (wrHit(wrEn, awIdx_q, `IDX_IRQ_ENABLE_LOW))
        enLow_q <= wByte_q & `LOW_WMASK;
      if (wrHit(wrEn, awIdx_q, `IDX_IRQ_ENABLE_MID))
        enMid_q <= wByte_q;
      if (wrHit(wrEn, awIdx_q, `IDX_IRQ_ENABLE_HIGH))
        enHigh_q <= wByte_q & `LOW_WMASK;
    end
  end

  // ***********************************************************
  // input synchronisers and event edges
  // ***********************************************************
  localparam int NIN = 22;
  logic [NIN-1:0] rawIn, sync1_q, sync2_q, sync3_q, rise;
  assign rawIn = {voltageCrossing, softResetDone, tamperFaultMode,
                  reactiveNegative, activeNegative, apparentNoloadEvt,
                  rmsNoloadEvt, reactiveNoloadEvt, activeNoloadEvt,
                  freqOutPulse, energyOverflowEvt, energyHalfEvt,
                  waveformSampleEvt, currentPeakEvt, voltagePeakEvt,
                  lineCycleDoneEvt, crossingTimeoutEvt};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : gEdge
      assign rise[g] = sync2_q[g] && !sync3_q[g];
    end
  endgenerate

  logic tamperSync, tamperPrev_q, reactNeg, reactPrev_q, actNeg, actPrev_q;
  logic settled_q;
  assign tamperSync = sync2_q[19];
  assign reactNeg = sync2_q[18];
  assign actNeg = sync2_q[17];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tamperPrev_q <= 1'b0;
      reactPrev_q <= 1'b0;
      actPrev_q <= 1'b0;
      settled_q <= 1'b0;
    end else begin
      tamperPrev_q <= tamperSync;
      reactPrev_q <= reactNeg;
      actPrev_q <= actNeg;
      settled_q <= 1'b1;
    end
  end

  function automatic logic dirChange(input logic cur, input logic prev,
                                     input logic sel);
    dirChange = sel ? (prev && !cur) : (!prev && cur);
  endfunction

  // ***********************************************************
  // status flags
  // ***********************************************************
  byte_t setLow, setMid, setHigh, clrLow, clrMid, clrHigh;
  logic resetEnd_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) resetEnd_q <= 1'b0;
    else resetEnd_q <= !settled_q;
  end

  always_comb begin
    setLow = 8'h00;
    setLow[5] = settled_q && dirChange(tamperSync, tamperPrev_q,
                                       accCfg_q[`ACC_FAULT_BIT]);
    setLow[4] = settled_q && dirChange(reactNeg, reactPrev_q,
                                       accCfg_q[`ACC_VAR_BIT]);
    setLow[3] = settled_q && dirChange(actNeg, actPrev_q,
                                       accCfg_q[`ACC_AP_BIT]);
    setLow[2] = rise[16] || rise[15];
    setLow[1] = rise[14];
    setLow[0] = rise[13];
    setMid = {rise[12:11], rise[10:8], rise[7:5]};
    setHigh = 8'h00;
    setHigh[`RESET_END_BIT] = resetEnd_q || rise[20];
    setHigh[5] = rise[4];
    setHigh[4] = rise[3];
    setHigh[3] = rise[2];
    setHigh[2] = rise[1];
    setHigh[1] = rise[0];
    setHigh[0] = rise[21];
    clrLow = wrHit(wrEn, awIdx_q, `IDX_IRQ_STATUS_LOW) ?
             (~wByte_q & `LOW_WMASK) : 8'h00;
    clrMid = wrHit(wrEn, awIdx_q, `IDX_IRQ_STATUS_MID) ? ~wByte_q : 8'h00;
    clrHigh = wrHit(wrEn, awIdx_q, `IDX_IRQ_STATUS_HIGH) ?
              (~wByte_q & `HIGH_WMASK) : 8'h00;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stLow_q <= `STATUS_RESET;
      stMid_q <= `STATUS_RESET;
      stHigh_q <= `STATUS_RESET;
    end else begin
      stLow_q <= ((stLow_q & ~clrLow) | setLow) & `LOW_WMASK;
      stMid_q <= (stMid_q & ~clrMid) | setMid;
      stHigh_q <= ((stHigh_q & ~clrHigh) | setHigh) & `HIGH_WMASK;
    end
  end

  logic summary;
  assign summary = |(stLow_q & enLow_q) || |(stMid_q & enMid_q) ||
                   |(stHigh_q & enHigh_q);

  always_ff @(posedge clk_sys) begin
    if (!resetn) combinedIrq <= 1'b0;
    else combinedIrq <= summary;
  end

  // ***********************************************************
  // read channel
  // ***********************************************************
  assign evtLevels = {sync2_q[21], tamperSync, reactNeg, actNeg,
                      sync2_q[20], 3'h0};

  function automatic logic [7:0] readMux(input logic [7:0] idx,
                                         input logic sum);
    case (idx)
      `IDX_ZERO_CROSS_OUTPUT_CONFIG: readMux = zeroCrossCfg_q;
      `IDX_CHANNEL_CALIBRATION_CONFIG: readMux = calCfg_q;
      `IDX_ACCUMULATION_CONFIG: readMux = accCfg_q;
      `IDX_IRQ_ENABLE_LOW: readMux = enLow_q;
      `IDX_IRQ_ENABLE_MID: readMux = enMid_q;
      `IDX_IRQ_ENABLE_HIGH: readMux = enHigh_q;
      `IDX_IRQ_STATUS_LOW: readMux = stLow_q | {sum, 7'h00};
      `IDX_IRQ_STATUS_MID: readMux = stMid_q;
      `IDX_IRQ_STATUS_HIGH: readMux = stHigh_q;
      `IDX_EVENT_LEVELS: readMux = evtLevels;
      default: readMux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, readMux(addrIdx(s_axi_araddr), summary)};
        s_axi_rresp <= idxMapped(addrIdx(s_axi_araddr)) ?
                       RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // pin and channel control outputs
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      zeroCrossPinAOut <= 1'b0;
      zeroCrossPinAOe <= 1'b1;
      zeroCrossPinBOut <= 1'b0;
      zeroCrossPinBOe <= 1'b1;
      currentInputSelB <= 1'b0;
      voltageInputGround <= 1'b0;
      currentInputGround <= 1'b0;
    end else begin
      zeroCrossPinAOut <= sync2_q[21];
      zeroCrossPinAOe <= !zeroCrossCfg_q[`ZX_PIN_A_BIT];
      zeroCrossPinBOut <= sync2_q[21];
      zeroCrossPinBOe <= !zeroCrossCfg_q[`ZX_PIN_B_BIT];
      case (calCfg_q[`CAL_SEL_HI:`CAL_SEL_LO])
        `SEL_INPUT_A: currentInputSelB <= 1'b0;
        `SEL_INPUT_B: currentInputSelB <= 1'b1;
        default: currentInputSelB <= tamperUsesInputB;
      endcase
      voltageInputGround <= calCfg_q[`CAL_VGND_BIT];
      currentInputGround <= calCfg_q[`CAL_IGND_BIT];
    end
  end
endmodule

`default_nettype wire

// [rtl/metering_irq_params.svh]
// register offsets, field positions, reset values for metering irq block
`ifndef METERING_IRQ_PARAMS_SVH
`define METERING_IRQ_PARAMS_SVH

// printed offsets are register indices; byte address is four times these
`define IDX_ZERO_CROSS_OUTPUT_CONFIG 8'h2B
`define IDX_CHANNEL_CALIBRATION_CONFIG 8'h3D
`define IDX_IRQ_ENABLE_LOW 8'hD9
`define IDX_IRQ_ENABLE_MID 8'hDA
`define IDX_IRQ_ENABLE_HIGH 8'hDB
`define IDX_IRQ_STATUS_LOW 8'hDC
`define IDX_IRQ_STATUS_MID 8'hDD
`define IDX_IRQ_STATUS_HIGH 8'hDE
`define IDX_ACCUMULATION_CONFIG 8'h0F
`define IDX_EVENT_LEVELS 8'hF0

`define ZX_PIN_A_BIT 1
`define ZX_PIN_B_BIT 0
`define CAL_SEL_HI 5
`define CAL_SEL_LO 4
`define CAL_VGND_BIT 3
`define CAL_IGND_BIT 2
`define ACC_FAULT_BIT 6
`define ACC_VAR_BIT 5
`define ACC_AP_BIT 4
`define SUMMARY_BIT 7
`define RESET_END_BIT 7
`define SEL_INPUT_A 2'h1
`define SEL_INPUT_B 2'h2

`define ZX_CFG_RESET 8'h00
`define CAL_CFG_RESET 8'h00
`define ACC_CFG_RESET 8'h00
`define ENABLE_RESET 8'h00
`define STATUS_RESET 8'h00
`define LOW_WMASK 8'h3F
`define HIGH_WMASK 8'hBF

`endif

// [rtl/metering_irq_pkg.sv]
// types shared by the metering interrupt and configuration block
package metering_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] resp_t;
  localparam resp_t RESP_OKAY = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;
endpackage

// [verification/metering_irq_properties.sv]
// port-level checker for the metering irq block
`timescale 1ns/10ps
`default_nettype none
module metering_irq_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic s_axi_bvalid,
  input wire logic voltageCrossing,
  input wire logic tamperUsesInputB,
  input wire logic zeroCrossPinAOut,
  input wire logic zeroCrossPinAOe,
  input wire logic zeroCrossPinBOut,
  input wire logic zeroCrossPinBOe,
  input wire logic currentInputSelB,
  input wire logic voltageInputGround,
  input wire logic currentInputGround,
  input wire logic combinedIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ****************
  // sequences
  // ****************
  sequence s_wrote;
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endsequence
  sequence s_xing_still;
    $stable(voltageCrossing) [*5];
  endsequence
  sequence s_sel_cause;
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) ||
      $past(tamperUsesInputB) != $past(tamperUsesInputB, 2);
  endsequence
  // ****************
  // properties
  // ****************
  property p_pin_a_oe;
    $changed(zeroCrossPinAOe) |-> s_wrote;
  endproperty
  property p_pin_b_oe;
    $changed(zeroCrossPinBOe) |-> s_wrote;
  endproperty
  property p_pin_a_out;
    s_xing_still ##0 !zeroCrossPinAOe |-> zeroCrossPinAOut == voltageCrossing;
  endproperty
  property p_pin_b_out;
    s_xing_still ##0 !zeroCrossPinBOe |-> zeroCrossPinBOut == voltageCrossing;
  endproperty
  property p_sel;
    $changed(currentInputSelB) |-> s_sel_cause;
  endproperty
  property p_vgnd;
    $changed(voltageInputGround) |-> s_wrote;
  endproperty
  property p_ignd;
    $changed(currentInputGround) |-> s_wrote;
  endproperty
  property p_irq_hold;
    $fell(combinedIrq) |-> s_wrote;
  endproperty
  a_pin_a_oe: assert property (p_pin_a_oe)
    else $error("pin a enable moved without write");
  a_pin_b_oe: assert property (p_pin_b_oe)
    else $error("pin b enable moved without write");
  a_pin_a_out: assert property (p_pin_a_out)
    else $error("pin a level wrong");
  a_pin_b_out: assert property (p_pin_b_out)
    else $error("pin b level wrong");
  a_sel: assert property (p_sel)
    else $error("channel select moved without cause");
  a_vgnd: assert property (p_vgnd)
    else $error("voltage ground moved without write");
  a_ignd: assert property (p_ignd)
    else $error("current ground moved without write");
  a_irq_hold: assert property (p_irq_hold)
    else $error("combined irq fell without write");
endmodule
bind metering_irq_status_and_config metering_irq_properties props (
  .clk_sys(clk_sys), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid),
  .voltageCrossing(voltageCrossing), .tamperUsesInputB(tamperUsesInputB),
  .zeroCrossPinAOut(zeroCrossPinAOut), .zeroCrossPinAOe(zeroCrossPinAOe),
  .zeroCrossPinBOut(zeroCrossPinBOut), .zeroCrossPinBOe(zeroCrossPinBOe),
  .currentInputSelB(currentInputSelB),
  .voltageInputGround(voltageInputGround),
  .currentInputGround(currentInputGround), .combinedIrq(combinedIrq)
);
`default_nettype wire

// [verification/metering_event_source.sv]
// model of the metering front end raising event lines
`timescale 1ns/10ps
`default_nettype none
module metering_event_source (
  input wire logic clk_sys,
  input wire logic fire,
  input wire logic [17:0] mask,
  output logic [17:0] evt
);
  logic [2:0] holdQ = 3'h0;
  logic [17:0] evtQ = 18'h0;
  assign evt = evtQ;
  // events stand four cycles, then drop low
  always @(posedge clk_sys) begin
    if (fire) begin
      evtQ <= mask;
      holdQ <= 3'h3;
    end else if (holdQ != 3'h0) begin
      holdQ <= holdQ - 3'h1;
    end else begin
      evtQ <= 18'h0;
    end
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench of the metering irq status and config block
`include "metering_irq_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  import metering_irq_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, fire = 1'b0, voltageCrossing = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tamperUsesInputB = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] lv = 3'h0;
  logic [17:0] evMask = 18'h0, evt;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  resp_t s_axi_bresp, s_axi_rresp;
  logic zeroCrossPinAOut, zeroCrossPinAOe, zeroCrossPinBOut, zeroCrossPinBOe;
  logic currentInputSelB, voltageInputGround, currentInputGround, combinedIrq;
  int bad_count = 0, checked = 0, cyc = 0;
  metering_irq_status_and_config dut (
    .clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .voltageCrossing, .softResetDone(evt[5]), .tamperFaultMode(lv[2]),
    .reactiveNegative(lv[1]), .activeNegative(lv[0]),
    .apparentNoloadEvt(evt[16]), .rmsNoloadEvt(evt[17]),
    .reactiveNoloadEvt(evt[15]), .activeNoloadEvt(evt[14]),
    .freqOutPulse(evt[13:12]), .energyOverflowEvt(evt[11:9]),
    .energyHalfEvt(evt[8:6]), .waveformSampleEvt(evt[4]),
    .currentPeakEvt(evt[3]), .voltagePeakEvt(evt[2]),
    .lineCycleDoneEvt(evt[1]), .crossingTimeoutEvt(evt[0]), .tamperUsesInputB,
    .zeroCrossPinAOut, .zeroCrossPinAOe, .zeroCrossPinBOut, .zeroCrossPinBOe,
    .currentInputSelB, .voltageInputGround, .currentInputGround, .combinedIrq
  );
  metering_event_source model (.clk_sys, .fire, .mask(evMask), .evt);
  always #12.5 clk_sys = ~clk_sys;
  // ****************
  // bus and compare tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR time %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input resp_t e);
    @(posedge clk_sys);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask
  task automatic wrs(input logic [7:0] idx, input logic [7:0] d);
    wr(idx, d, RESP_OKAY);
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output resp_t r);
    @(posedge clk_sys);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    resp_t r;
    rd(idx, d, r);
    chk(d, {24'h0, e});
  endtask
  task automatic pulse(input logic [17:0] m);
    @(posedge clk_sys);
    evMask <= m;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    logic [31:0] d;
    resp_t r;
    rdc(`IDX_ZERO_CROSS_OUTPUT_CONFIG, 8'h00);
    rdc(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h00);
    rdc(`IDX_IRQ_ENABLE_LOW, 8'h00);
    rdc(`IDX_IRQ_STATUS_LOW, 8'h00);
    rdc(`IDX_IRQ_STATUS_MID, 8'h00);
    rdc(`IDX_IRQ_STATUS_HIGH, 8'h80);
    chk({zeroCrossPinAOe, zeroCrossPinBOe}, 2'h3);
    rd(8'h11, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h11, 8'h5A, RESP_SLVERR);
  endtask
  task automatic t_pins;
    wrs(`IDX_ZERO_CROSS_OUTPUT_CONFIG, 8'h02);
    voltageCrossing <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({zeroCrossPinAOe, zeroCrossPinAOut, zeroCrossPinBOe}, 3'h3);
    rdc(`IDX_IRQ_STATUS_HIGH, 8'h81);
    wrs(`IDX_ZERO_CROSS_OUTPUT_CONFIG, 8'h01);
    voltageCrossing <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({zeroCrossPinBOe, zeroCrossPinBOut, zeroCrossPinAOe}, 3'h1);
    wrs(`IDX_ZERO_CROSS_OUTPUT_CONFIG, 8'h00);
    chk({zeroCrossPinAOe, zeroCrossPinBOe}, 2'h3);
    wrs(`IDX_IRQ_STATUS_HIGH, 8'h00);
  endtask
  task automatic t_cal;
    tamperUsesInputB <= 1'b1;
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h10);
    chk(currentInputSelB, 1'b0);
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h20);
    chk(currentInputSelB, 1'b1);
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h30);
    chk(currentInputSelB, 1'b1);
    tamperUsesInputB <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(currentInputSelB, 1'b0);
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h0C);
    chk({voltageInputGround, currentInputGround}, 2'h3);
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h04);
    chk({voltageInputGround, currentInputGround}, 2'h1);
    rdc(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h04);
    wrs(`IDX_CHANNEL_CALIBRATION_CONFIG, 8'h00);
  endtask
  task automatic t_events;
    logic [7:0] idx, b;
    for (int i = 0; i < 18; i++) begin
      if (i < 6) begin
        idx = `IDX_IRQ_STATUS_HIGH;
        b = (i == 5) ? 8'h80 : 8'h02 << i;
      end else if (i < 14) begin
        idx = `IDX_IRQ_STATUS_MID;
        b = 8'h01 << (i - 6);
      end else begin
        idx = `IDX_IRQ_STATUS_LOW;
        b = (i == 17) ? 8'h04 : 8'h01 << (i - 14);
      end
      pulse(18'h1 << i);
      rdc(idx, b);
      chk(combinedIrq, 1'b0);
      repeat (20) @(posedge clk_sys);
      rdc(idx, b);
      wrs(idx, 8'h00);
      rdc(idx, 8'h00);
    end
  endtask
  task automatic t_sign;
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      b = 8'h08 << k;
      for (int c = 0; c < 2; c++) begin
        wrs(`IDX_ACCUMULATION_CONFIG, c ? (8'h10 << k) : 8'h00);
        lv[k] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdc(`IDX_IRQ_STATUS_LOW, c ? 8'h00 : b);
        rdc(`IDX_EVENT_LEVELS, 8'h10 << k);
        wrs(`IDX_IRQ_STATUS_LOW, 8'h00);
        lv[k] <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdc(`IDX_IRQ_STATUS_LOW, c ? b : 8'h00);
        wrs(`IDX_IRQ_STATUS_LOW, 8'h00);
      end
    end
  endtask
  task automatic t_irq;
    wrs(`IDX_IRQ_ENABLE_MID, 8'h40);
    pulse(18'h1 << 13);
    chk(combinedIrq, 1'b0);
    pulse(18'h1 << 12);
    chk(combinedIrq, 1'b1);
    rdc(`IDX_IRQ_STATUS_LOW, 8'h80);
    wrs(`IDX_IRQ_STATUS_MID, 8'h80);
    chk(combinedIrq, 1'b0);
    rdc(`IDX_IRQ_STATUS_LOW, 8'h00);
    rdc(`IDX_IRQ_STATUS_MID, 8'h80);
    wrs(`IDX_IRQ_ENABLE_MID, 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc(`IDX_IRQ_STATUS_HIGH, 8'h80);
    rdc(`IDX_IRQ_STATUS_MID, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    $display("reset and map test done");
    t_pins;
    $display("crossing pin test done");
    t_cal;
    $display("channel test done");
    t_events;
    $display("event flag test done");
    t_sign;
    $display("sign direction test done");
    t_irq;
    $display("summary irq test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
